// ===== bench/msg_sink.sv
// Interconnect model that accepts interrupt message writes.
// Assumes the bench stalls it to hold a message on the port.
`timescale 1ns/1ps
module msg_sink (
	input wire logic clock,
	input wire logic rst,
	input wire logic stall,
	input wire logic messageValid,
	output logic messageReady,
	output int taken
);
	// Ready is a plain level; stalling shows the slow answer
	assign messageReady = !stall;
	always_ff @(posedge clock) taken <= rst ? 0 : taken + (messageValid && messageReady);
endmodule

// ===== bench/perfmon_interrupt_signalling_tb.sv
// Self-checking bench for the perf-monitor interrupt block.
// Assumes the sink model and the bound checker sit beside it.
`timescale 1ns/1ps
module perfmon_interrupt_signalling_tb;
	logic clock = 0, rst = 1, regWrite = 0, regRead = 0, cap = 1, stall = 1, vld, rdy;
	logic blk = 0;
	logic [11:0] regAddress = 12'h0;
	logic [31:0] regWriteData = 32'h0, rdata, mdata;
	logic [7:0] ovf = 8'h0;
	logic [63:0] maddr;
	logic sts, pend;
	int taken, fail_count = 0, check_count = 0;
	perfmon_interrupt_signalling uut (.clock(clock), .rst(rst), .regAddress(regAddress),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(rdata), .counting_support_capability(cap), .counterOverflow(ovf),
		.overflowIntEnable(8'h0f), .messageBlocked(blk), .messageReady(rdy),
		.messageValid(vld), .messageAddress(maddr), .messageData(mdata),
		.event_status_flag(sts), .message_pending_flag(pend));
	msg_sink sink (.clock(clock), .rst(rst), .stall(stall), .messageValid(vld),
		.messageReady(rdy), .taken(taken));
	initial forever #4 clock = !clock;
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock) {regWrite, regAddress, regWriteData} <= {1'b1, a, d};
		@(posedge clock) regWrite <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock) {regRead, regAddress} <= {1'b1, a};
		@(posedge clock) regRead <= 0;
		#1 chk("readData", e, rdata);
	endtask
	// One overflow pulse; the message, if any, stands one cycle later
	task pulse;
		@(posedge clock) ovf <= 8'h88;
		@(posedge clock) ovf <= 8'h0;
		#1;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task t_defaults;
		rd(12'h328, 32'h8000_0000);
		rd(12'h32c, 32'h0);
		wr(12'h32c, 32'hffff_abcd);
		rd(12'h32c, 32'h0000_abcd);
		wr(12'h330, 32'h1234_5677);
		wr(12'h334, 32'hcafe_0001);
		wr(12'h328, 32'h0000_0005);
		rd(12'h328, 32'h5);
		$display("defaults done");
	endtask
	task t_send;
		pulse;
		chk("valid", 1, vld);
		chk("address", 64'hcafe_0001_1234_5674, maddr);
		chk("data", 32'habcd, mdata);
		pulse;
		stall <= 0;
		repeat (4) @(posedge clock);
		chk("taken", 1, taken);
		rd(12'h324, 32'h1);
		wr(12'h324, 32'h1);
		rd(12'h324, 32'h0);
		$display("send done");
	endtask
	task t_held;
		wr(12'h328, 32'h8000_0000);
		pulse;
		rd(12'h328, 32'hc000_0000);
		wr(12'h328, 32'h0);
		#1 chk("valid", 1, vld);
		rd(12'h328, 32'h0);
		wr(12'h324, 32'h1);
		wr(12'h328, 32'h8000_0000);
		pulse;
		wr(12'h324, 32'h1);
		rd(12'h328, 32'h8000_0000);
		chk("taken", 2, taken);
		$display("held done");
	endtask
	// Transient block holds the message; its end releases it
	task t_block;
		wr(12'h328, 32'h0);
		blk <= 1;
		pulse;
		chk("valid", 0, vld);
		rd(12'h328, 32'h4000_0000);
		@(posedge clock) blk <= 0;
		@(posedge clock) #1 chk("valid", 1, vld);
		rd(12'h328, 32'h0);
		chk("taken", 3, taken);
		wr(12'h324, 32'h1);
		@(posedge clock) ovf <= 8'hf0;
		@(posedge clock) ovf <= 8'h0;
		rd(12'h324, 32'h0);
		$display("block done");
	endtask
	task t_absent;
		cap <= 0;
		wr(12'h32c, 32'h1);
		rd(12'h32c, 32'h0);
		rd(12'h328, 32'h0);
		cap <= 1;
		rd(12'h32c, 32'h0000_abcd);
		$display("absent done");
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst <= 0;
		t_defaults;
		t_send;
		t_held;
		t_block;
		t_absent;
		end_of_test;
	end
	initial begin
		#20000;
		fail_count++;
		end_of_test;
	end
endmodule

// ===== bench/perfmon_intr_sva.sv
// Checker for the perf-monitor interrupt block, bound to its ports.
// Assumes one clock; the mask bit is shadowed here from control writes.
`timescale 1ns/1ps
module perfmon_intr_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic [11:0] regAddress,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regReadData,
	input wire logic counting_support_capability,
	input wire logic [7:0] counterOverflow,
	input wire logic [7:0] overflowIntEnable,
	input wire logic messageBlocked,
	input wire logic messageValid,
	input wire logic event_status_flag,
	input wire logic message_pending_flag
);
	logic mask;
	wire cap = counting_support_capability;
	wire ev = cap && |(counterOverflow & overflowIntEnable);
	wire wrCtl = cap && regWrite && regAddress == 12'h328;
	wire clr = cap && regWrite && regAddress == 12'h324 && regWriteData[0];
	wire nm = wrCtl ? regWriteData[31] : mask;
	// Mask is not a port, so keep a shadow of it
	always_ff @(posedge clock) mask <= rst ? 1'b1 : nm;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	set_status_a: assert property (ev |=> event_status_flag)
		else $error("status flag not set");
	hold_status_a: assert property (event_status_flag && !clr |=> event_status_flag)
		else $error("status flag lost");
	clear_status_a: assert property (clr && !ev |=> !event_status_flag)
		else $error("status flag not cleared");
	send_open_a: assert property (ev && !event_status_flag && !nm && !messageBlocked && !messageValid
		|=> messageValid) else $error("message not sent");
	masked_quiet_a: assert property (mask && !wrCtl |=> !$rose(messageValid))
		else $error("message sent while masked");
	hold_pend_a: assert property (ev && !event_status_flag && nm |=> message_pending_flag)
		else $error("pending flag not set");
	unmask_send_a: assert property (message_pending_flag && wrCtl && !regWriteData[31]
		&& !messageBlocked && !clr && !messageValid |=> messageValid && !message_pending_flag)
		else $error("held message not delivered");
	clear_drop_a: assert property (message_pending_flag && clr && !ev
		|=> !message_pending_flag && !$rose(messageValid)) else $error("pending not dropped");
	absent_zero_a: assert property (regRead && !cap |=> regReadData == 32'h0)
		else $error("read data not zero");
	cover property (messageValid && !mask);
	cover property (message_pending_flag && clr);
	cover property ($fell(message_pending_flag) && messageValid);
endmodule
bind perfmon_interrupt_signalling perfmon_intr_sva chk (.*);

// ===== include/perfmon_intr_pkg.sv
// Constants for the performance-monitoring interrupt signalling block.
// Assumes a single clock domain and a plain strobe register port.
//
// Overview of operation
// - Overflow of a counter with interrupt-on-overflow set raises the status flag.
// - Unmasked event issues a message using programmed data and address.
// - Mask set forbids any message; mask resets to one, read/write.
// - Held-back event sets read-only pending bit 30; pending resets to zero.
// - Clearing mask while pending delivers the held message at once, unless the path is blocked or a message still waits on the port.
// - Pending clears when the held message is actually sent.
// - Writing one to clear status also clears pending without sending.
// - Data register holds 16-bit value, reset zero, upper bits read zero.
// - Without monitoring support, status, control and data read zero, ignore writes.
// - Address is dword-aligned lower field plus upper 32-bit register.
package perfmon_intr_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] STATUS_OFFSET = 12'h324;
	localparam logic [11:0] CONTROL_OFFSET = 12'h328;
	localparam logic [11:0] DATA_OFFSET = 12'h32c;
	localparam logic [11:0] LOWER_ADDR_OFFSET = 12'h330;
	localparam logic [11:0] UPPER_ADDR_OFFSET = 12'h334;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int STATUS_FLAG_BIT = 0;
	localparam int MASK_BIT = 31;
	localparam int PENDING_BIT = 30;
	localparam int DATA_WIDTH = 16;
	localparam logic MASK_RESET = 1'b1;
	localparam logic PENDING_RESET = 1'b0;
	localparam logic [29:0] CONTROL_RSVD_RESET = 30'h0;
	localparam logic [15:0] DATA_RESET = 16'h0;
	localparam logic [29:0] LOWER_ADDR_RESET = 30'h0;
	localparam logic [31:0] UPPER_ADDR_RESET = 32'h0;
	localparam int COUNTER_COUNT = 8;
endpackage

// ===== verilog/perfmon_interrupt_signalling.sv
// Performance-monitoring interrupt signalling: status, mask, pending, message.
// Assumes overflow pulses arrive on this clock; message port is a valid/ready pair.
`timescale 1ns/1ps
module perfmon_interrupt_signalling (
	input wire logic clock,
	input wire logic rst,
	input wire logic [11:0] regAddress,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regReadData,
	input wire logic counting_support_capability,
	input wire logic [perfmon_intr_pkg::COUNTER_COUNT-1:0] counterOverflow,
	input wire logic [perfmon_intr_pkg::COUNTER_COUNT-1:0] overflowIntEnable,
	input wire logic messageBlocked,
	input wire logic messageReady,
	output logic messageValid,
	output logic [63:0] messageAddress,
	output logic [31:0] messageData,
	output logic event_status_flag,
	output logic message_pending_flag
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic message_mask_bit;
	logic [29:0] reserved_preserve;
	logic [15:0] dataValue;
	logic [29:0] message_lower_address;
	logic [31:0] message_upper_address;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Unsupported monitoring turns all five interrupt registers into zeros
	wire supported = counting_support_capability;
	wire hitStatus = (regAddress == perfmon_intr_pkg::STATUS_OFFSET);
	wire hitControl = (regAddress == perfmon_intr_pkg::CONTROL_OFFSET);
	wire hitData = (regAddress == perfmon_intr_pkg::DATA_OFFSET);
	wire hitLower = (regAddress == perfmon_intr_pkg::LOWER_ADDR_OFFSET);
	wire hitUpper = (regAddress == perfmon_intr_pkg::UPPER_ADDR_OFFSET);
	wire wrStatus = regWrite && hitStatus && supported;
	wire wrControl = regWrite && hitControl && supported;
	wire wrData = regWrite && hitData && supported;
	wire wrLower = regWrite && hitLower && supported;
	wire wrUpper = regWrite && hitUpper && supported;

	// Status clears only on a one written to bit 0
	wire statusClear = wrStatus && regWriteData[perfmon_intr_pkg::STATUS_FLAG_BIT];
	// Overflow event qualified by the per-counter interrupt-on-overflow setting
	wire overflowEvent = supported && |(counterOverflow & overflowIntEnable);
	// A new event is one that finds status clear, so only one message per condition
	wire newEvent = overflowEvent && !event_status_flag;
	wire nextMask = wrControl ? regWriteData[perfmon_intr_pkg::MASK_BIT] : message_mask_bit;
	// A message may leave only while unmasked and the path is not blocked
	wire canSend = !nextMask && !messageBlocked;
	wire sendAccepted = messageValid && messageReady;

	// ----------------------------------------------------------------
	// Status flag: set wins over a simultaneous clear
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			event_status_flag <= 1'b0;
		end else if (overflowEvent) begin
			event_status_flag <= 1'b1;
		end else if (statusClear) begin
			event_status_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Reserved bits are stored as written so software read-modify-write works
	always_ff @(posedge clock) begin
		if (rst) begin
			message_mask_bit <= perfmon_intr_pkg::MASK_RESET;
			reserved_preserve <= perfmon_intr_pkg::CONTROL_RSVD_RESET;
		end else if (wrControl) begin
			message_mask_bit <= regWriteData[perfmon_intr_pkg::MASK_BIT];
			reserved_preserve <= regWriteData[29:0];
		end
	end

	// ----------------------------------------------------------------
	// Pending flag and message issue
	// ----------------------------------------------------------------
	// Pending holds a message that could not leave; a status clear drops it
	// unsent. A message already offered on the port stays until accepted.
	always_ff @(posedge clock) begin
		if (rst) begin
			message_pending_flag <= perfmon_intr_pkg::PENDING_RESET;
			messageValid <= 1'b0;
		end else begin
			if (sendAccepted) begin
				messageValid <= 1'b0;
			end else if (!messageValid && canSend && (newEvent || message_pending_flag)
				&& !(statusClear && !newEvent)) begin
				messageValid <= 1'b1;
			end
			// An event that meets an occupied port is held too, so it is never lost
			if (newEvent && (!canSend || messageValid)) begin
				message_pending_flag <= 1'b1;
			end else if (statusClear) begin
				message_pending_flag <= 1'b0;
			end else if (message_pending_flag && canSend && !messageValid) begin
				message_pending_flag <= 1'b0;
			end
		end
	end

	// Message contents are captured when the message is launched
	always_ff @(posedge clock) begin
		if (rst) begin
			messageAddress <= 64'h0;
			messageData <= 32'h0;
		end else if (!messageValid) begin
			messageAddress <= {message_upper_address, message_lower_address, 2'b00};
			messageData <= {16'h0, dataValue};
		end
	end

	// ----------------------------------------------------------------
	// Data and address registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			dataValue <= perfmon_intr_pkg::DATA_RESET;
			message_lower_address <= perfmon_intr_pkg::LOWER_ADDR_RESET;
			message_upper_address <= perfmon_intr_pkg::UPPER_ADDR_RESET;
		end else begin
			if (wrData) begin
				dataValue <= regWriteData[15:0];
			end
			if (wrLower) begin
				message_lower_address <= regWriteData[31:2];
			end
			if (wrUpper) begin
				message_upper_address <= regWriteData;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped or unsupported locations read zero
	logic [31:0] readMux;
	always_comb begin
		readMux = 32'h0;
		if (!supported) begin
			readMux = 32'h0;
		end else if (hitStatus) begin
			readMux = {31'h0, event_status_flag};
		end else if (hitControl) begin
			readMux = {message_mask_bit, message_pending_flag, reserved_preserve};
		end else if (hitData) begin
			readMux = {16'h0, dataValue};
		end else if (hitLower) begin
			readMux = {message_lower_address, 2'b00};
		end else if (hitUpper) begin
			readMux = message_upper_address;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			regReadData <= 32'h0;
		end else if (regRead) begin
			regReadData <= readMux;
		end else begin
			regReadData <= 32'h0;
		end
	end
endmodule
